// [rtl/rpd_power_ctrl.sv]
// power state, inactivity timer and invalid-level detector of an rs232 transceiver
// Notes on behaviour
// - powerdown stops pump, tristates all transmitter outputs
// - low shutdown input overrides keep-awake input
// - keep-awake high disables inactivity powerdown only
// - inactivity powerdown armed: keep-awake low, shutdown high
// - armed: 30 s without transitions powers down
// - auto powerdown left on any tx or rx data input transition
// - down: timer stays expired until wake event
// - keep-awake falling edge gives full 30 s
// - transmission resumes within 100 us of wake
// - invalid indicator low after 30 us all invalid
// - invalid indicator high 1 us after valid
// - invalid indicator never changes power state itself
// - invalid indicator works in every mode
// - ready low in powerdown, high once supply good
// - optional variant tristates receivers in powerdown
`timescale 1ns/10ps
`default_nettype none
`include "rpd_params.svh"
module rpd_power_ctrl
    import rpd_pkg::*;
#(
    parameter int NUM_TX = 3,
    parameter int NUM_RX = 5,
    parameter bit RX_DISABLE = 1'b1,
    parameter int IDLE_CYCLES = `RPD_IDLE_CYC,
    parameter int WAKE_CYCLES = `RPD_WAKE_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic shutdown_n_in,
    input wire logic keep_awake_in,
    input wire logic [NUM_TX-1:0] tx_data_in,
    input wire logic [NUM_RX-1:0] rx_data_in,
    input wire logic [NUM_RX-1:0] rx_level_valid_in,
    input wire logic neg_supply_ok_in,
    output logic tx_oe,
    output logic rx_oe,
    output logic pump_en,
    output logic ready,
    output logic invalid_n,
    output rpd_status_type status
);
    localparam int NIN = NUM_TX + NUM_RX + NUM_RX + 3;
    localparam int INV_CYC = `RPD_INVALID_CYC;
    localparam int VAL_CYC = `RPD_VALID_CYC;

    // three-stage synchronisers; a change counts while stages two and three differ
    logic [NIN-1:0] s1_reg, s2_reg, s3_reg;
    logic [NIN-1:0] s1_next, s2_next, s3_next;
    always_comb begin
        s1_next = {shutdown_n_in, keep_awake_in, neg_supply_ok_in,
                   rx_level_valid_in, rx_data_in, tx_data_in};
        s2_next = s1_reg;
        s3_next = s2_reg;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // shutdown starts released, else reset would read as a manual powerdown
            s1_reg <= {`RPD_SYNC_RST, {(NIN-3){1'b0}}};
            s2_reg <= {`RPD_SYNC_RST, {(NIN-3){1'b0}}};
            s3_reg <= {`RPD_SYNC_RST, {(NIN-3){1'b0}}};
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    logic activity;
    logic kaw_fall;
    logic kaw_rise;
    logic shut_n;
    logic kaw;
    logic supply_ok;
    logic any_valid;
    always_comb begin
        activity = |(s2_reg[NUM_TX+NUM_RX-1:0] ^ s3_reg[NUM_TX+NUM_RX-1:0]);
        shut_n = s3_reg[NIN-1];
        kaw = s3_reg[NIN-2];
        supply_ok = s3_reg[NIN-3];
        any_valid = |s3_reg[NUM_TX+2*NUM_RX-1:NUM_TX+NUM_RX];
        kaw_rise = s2_reg[NIN-2] & ~s3_reg[NIN-2];
        kaw_fall = ~s2_reg[NIN-2] & s3_reg[NIN-2];
    end

    // power state and inactivity timer
    rpd_mode_type mode_reg, mode_next;
    logic [31:0] idle_reg, idle_next;
    logic [15:0] wake_reg, wake_next;
    logic ready_reg, ready_next;
    always_comb begin
        mode_next = mode_reg;
        idle_next = idle_reg;
        wake_next = wake_reg;
        ready_next = ready_reg;
        if (!shut_n) begin
            mode_next = RPD_MANUAL_DOWN;
            idle_next = 32'h0000_0000;
        end else if (mode_reg != RPD_ACTIVE) begin
            if (activity || kaw_rise || (kaw && mode_reg == RPD_MANUAL_DOWN)) begin
                mode_next = RPD_ACTIVE;
                idle_next = 32'(IDLE_CYCLES);
            end
        end else if (kaw || activity || kaw_fall) begin
            idle_next = 32'(IDLE_CYCLES);
        end else if (idle_reg <= 32'h0000_0001) begin
            mode_next = RPD_AUTO_DOWN;
            idle_next = 32'h0000_0000;
        end else begin
            idle_next = idle_reg - 32'h0000_0001;
        end
        // ready falls on entry to powerdown, rises once supply is good
        if (mode_next != RPD_ACTIVE) begin
            ready_next = 1'b0;
            wake_next = 16'(WAKE_CYCLES);
        end else if (wake_reg != 16'h0000) begin
            wake_next = wake_reg - 16'h0001;
            ready_next = supply_ok;
        end else begin
            // bounded wake: never wait past the recovery window
            ready_next = 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_reg <= RPD_ACTIVE;
            idle_reg <= 32'(IDLE_CYCLES);
            wake_reg <= 16'(WAKE_CYCLES);
            ready_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            idle_reg <= idle_next;
            wake_reg <= wake_next;
            ready_reg <= ready_next;
        end
    end

    // invalid-level detector, independent of the power state
    logic [15:0] inv_reg, inv_next;
    logic invn_reg, invn_next;
    always_comb begin
        inv_next = inv_reg;
        invn_next = invn_reg;
        if (any_valid) begin
            if (inv_reg >= 16'(VAL_CYC - 1)) begin
                invn_next = 1'b1;
            end else begin
                inv_next = inv_reg + 16'h0001;
            end
            if (invn_reg) begin
                inv_next = 16'h0000;
            end
        end else if (invn_reg) begin
            if (inv_reg >= 16'(INV_CYC - 1)) begin
                invn_next = 1'b0;
                inv_next = 16'h0000;
            end else begin
                inv_next = inv_reg + 16'h0001;
            end
        end else begin
            inv_next = 16'h0000;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            inv_reg <= 16'h0000;
            invn_reg <= 1'b0;
        end else begin
            inv_reg <= inv_next;
            invn_reg <= invn_next;
        end
    end

    // outputs; invalid_n feeds nothing in the power path
    logic down;
    always_comb begin
        down = (mode_reg != RPD_ACTIVE);
        pump_en = ~down;
        tx_oe = ~down & ready_reg;
        rx_oe = ~(RX_DISABLE & down);
        ready = ready_reg;
        invalid_n = invn_reg;
        status = '{powered_down: down, pump_en: ~down, ready: ready_reg,
                   invalid_n: invn_reg};
    end

    // cycles spent awake with transmitters still off; bounds the resume time
    logic [15:0] resume_reg, resume_next;
    always_comb begin
        resume_next = resume_reg;
        if (down || tx_oe) begin
            resume_next = 16'h0000;
        end else if (resume_reg != 16'hffff) begin
            resume_next = resume_reg + 16'h0001;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            resume_reg <= 16'h0000;
        end else begin
            resume_reg <= resume_next;
        end
    end

    pump_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_reg != RPD_ACTIVE) |-> (!pump_en && !tx_oe))
        else $error("pump or transmitter on while down");
    shut_prio_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !shut_n |=> mode_reg == RPD_MANUAL_DOWN)
        else $error("shutdown did not force powerdown");
    keep_on_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (shut_n && kaw && mode_reg == RPD_ACTIVE) |=> mode_reg == RPD_ACTIVE)
        else $error("powered down while keep-awake high");
    auto_arm_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_reg == RPD_ACTIVE && mode_next == RPD_AUTO_DOWN) |-> (!kaw && shut_n))
        else $error("auto powerdown while not armed");
    wake_act_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_reg == RPD_AUTO_DOWN && shut_n && activity) |=> mode_reg == RPD_ACTIVE)
        else $error("transition did not wake device");
    kaw_fall_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (shut_n && kaw_fall && mode_reg == RPD_ACTIVE) |=> idle_reg == 32'(IDLE_CYCLES))
        else $error("keep-awake fall did not restart timer");
    ready_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(mode_reg != RPD_ACTIVE) |-> !ready)
        else $error("ready high in powerdown");
    wake_time_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        resume_reg <= 16'(WAKE_CYCLES + 1))
        else $error("transmission not resumed in time");
    inv_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(invalid_n) |-> $past(!any_valid))
        else $error("invalid fell with a valid level");
    rx_hiz_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        RX_DISABLE && down |-> !rx_oe)
        else $error("receivers driven while down");
endmodule
`default_nettype wire

// [rtl/rpd_params.svh]
// timing constants and reset values for the rs232 powerdown controller
`ifndef RPD_PARAMS_SVH
`define RPD_PARAMS_SVH
`define RPD_CLK_HZ 50000000
`define RPD_IDLE_S 30
`define RPD_IDLE_CYC (`RPD_CLK_HZ * `RPD_IDLE_S)
`define RPD_INVALID_US 30
`define RPD_INVALID_CYC ((`RPD_CLK_HZ / 1000000) * `RPD_INVALID_US)
`define RPD_VALID_US 1
`define RPD_VALID_CYC ((`RPD_CLK_HZ / 1000000) * `RPD_VALID_US)
`define RPD_WAKE_US 100
`define RPD_WAKE_CYC ((`RPD_CLK_HZ / 1000000) * `RPD_WAKE_US)
`define RPD_SYNC_RST 3'h4
`endif

// [rtl/rpd_pkg.sv]
// types for the rs232 powerdown controller
package rpd_pkg;
    typedef enum logic [1:0] {
        RPD_ACTIVE,
        RPD_AUTO_DOWN,
        RPD_MANUAL_DOWN
    } rpd_mode_type;

    typedef struct packed {
        logic powered_down;
        logic pump_en;
        logic ready;
        logic invalid_n;
    } rpd_status_type;
endpackage

// [sim/rpd_line_model.sv]
// far-side model: rs232 line activity and the pumped negative supply
`timescale 1ns/10ps
`default_nettype none
module rpd_line_model #(
    parameter int NUM_TX = 3,
    parameter int NUM_RX = 5
) (
    input wire logic clk_sys,
    input wire logic pump_en,
    input wire logic [NUM_TX+NUM_RX-1:0] kick,
    output logic [NUM_TX-1:0] tx_data,
    output logic [NUM_RX-1:0] rx_data,
    output logic neg_ok
);
    int ramp = 0;
    initial begin
        tx_data = '0;
        rx_data = '0;
        neg_ok = 1'b0;
    end
    // each kick bit flips one line for one edge, so every kick is one transition
    always @(posedge clk_sys) begin
        {rx_data, tx_data} <= {rx_data, tx_data} ^ kick;
        ramp <= pump_en ? ramp + 1 : 0;
        // supply needs a few cycles to pump down, drops at once when the pump stops
        neg_ok <= pump_en && (ramp >= 10);
    end
endmodule
`default_nettype wire

// [sim/rs232_powerdown_control_bench.sv]
// self-checking bench for the rs232 powerdown controller
`timescale 1ns/10ps
`default_nettype none
module rs232_powerdown_control_bench;
    import rpd_pkg::*;
    localparam int IDLE = 200;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic shutdown_n_in = 1'b1;
    logic keep_awake_in = 1'b1;
    logic [7:0] kick = 8'h00;
    logic [4:0] valid = 5'h1f;
    logic [2:0] tx;
    logic [4:0] rx;
    logic neg_ok, tx_oe, rx_oe, pump_en, ready, invalid_n;
    rpd_status_type status;
    int miscompares = 0;
    int n_tests = 0;
    int n;
    logic [31:0] seed = 32'h0000_ca84;
    always #10 clk_sys = ~clk_sys;
    rpd_line_model line (.clk_sys(clk_sys), .pump_en(pump_en), .kick(kick), .tx_data(tx),
        .rx_data(rx), .neg_ok(neg_ok));
    rpd_power_ctrl #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(20)) uut (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .shutdown_n_in(shutdown_n_in), .keep_awake_in(keep_awake_in),
        .tx_data_in(tx), .rx_data_in(rx), .rx_level_valid_in(valid),
        .neg_supply_ok_in(neg_ok), .tx_oe(tx_oe), .rx_oe(rx_oe), .pump_en(pump_en),
        .ready(ready), .invalid_n(invalid_n), .status(status));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_win(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // bounded wait on pump_en (0), invalid_n (1) or ready (2); a hang ends the run
    task wait_for(input int sel, input logic v, input int lim);
        n = 0;
        while (n < lim && (sel == 0 ? pump_en : sel == 1 ? invalid_n : ready) !== v) begin
            cyc(1);
            n++;
        end
        if (n == lim) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task toggle();
        seed = lfsr(seed);
        kick = 8'h01 << seed[2:0];
        cyc(1);
        kick = 8'h00;
    endtask
    initial begin
        cyc(2);
        sys_rst = 1'b0;
        wait_for(2, 1'b1, 60);
        chk(tx_oe, 1'b1);
        chk(status.ready, 1'b1);
        // indicator must be high before the invalid timing can be measured
        wait_for(1, 1'b1, 80);
        chk(status.invalid_n, 1'b1);
        valid = 5'h00;
        wait_for(1, 1'b0, 1600);
        chk_win(n, 1500, 1510);
        chk(pump_en, 1'b1);
        seed = lfsr(seed);
        valid[seed % 5] = 1'b1;
        wait_for(1, 1'b1, 80);
        chk_win(n, 50, 58);
        valid = 5'h1f;
        cyc(IDLE + 100);
        chk(pump_en, 1'b1);
        shutdown_n_in = 1'b0;
        wait_for(0, 1'b0, 8);
        chk(tx_oe, 1'b0);
        chk(rx_oe, 1'b0);
        chk(ready, 1'b0);
        chk(status.powered_down, 1'b1);
        valid = 5'h00;
        wait_for(1, 1'b0, 1600);
        chk_win(n, 1500, 1510);
        valid = 5'h1f;
        keep_awake_in = 1'b0;
        toggle();
        cyc(20);
        chk(pump_en, 1'b0);
        shutdown_n_in = 1'b1;
        cyc(50);
        chk(pump_en, 1'b0);
        toggle();
        wait_for(0, 1'b1, 12);
        wait_for(0, 1'b0, IDLE + 20);
        chk_win(n, IDLE - 10, IDLE + 12);
        cyc(IDLE + 50);
        chk(status.pump_en, 1'b0);
        toggle();
        wait_for(0, 1'b1, 12);
        // transmitters stay off until ready, so only the power state and rx_oe are checked here
        chk(status.powered_down, 1'b0);
        chk(rx_oe, 1'b1);
        wait_for(2, 1'b1, 40);
        chk_win(n, 1, 22);
        chk(tx_oe, 1'b1);
        keep_awake_in = 1'b1;
        cyc(10);
        keep_awake_in = 1'b0;
        wait_for(0, 1'b0, IDLE + 20);
        chk_win(n, IDLE, IDLE + 12);
        keep_awake_in = 1'b1;
        wait_for(0, 1'b1, 12);
        chk(pump_en, 1'b1);
        // both control inputs joined as one shutdown line
        shutdown_n_in = 1'b0;
        keep_awake_in = 1'b0;
        wait_for(0, 1'b0, 8);
        chk(status.powered_down, 1'b1);
        shutdown_n_in = 1'b1;
        keep_awake_in = 1'b1;
        wait_for(0, 1'b1, 8);
        chk(pump_en, 1'b1);
        // invalid indicator looped back onto both control inputs
        valid = 5'h00;
        wait_for(1, 1'b0, 1600);
        shutdown_n_in = invalid_n;
        keep_awake_in = invalid_n;
        wait_for(0, 1'b0, 8);
        chk(status.powered_down, 1'b1);
        valid = 5'h1f;
        wait_for(1, 1'b1, 80);
        shutdown_n_in = invalid_n;
        keep_awake_in = invalid_n;
        wait_for(0, 1'b1, 8);
        chk(pump_en, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
